/* File: logic/sie_pkg.sv */
/*
 Package for the serial interrupt, error and autobaud block.
 Holds register offsets, field layouts, mode codes and reload values.
 Assumes a single 20 MHz module clock and one Avalon-MM slave port.
*/
`default_nettype none
package sie_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [3:0] SIE_OFF_CTRL = 4'h0;
    localparam logic [3:0] SIE_OFF_BAUD = 4'h4;
    localparam logic [3:0] SIE_OFF_STAT = 4'h8;
    localparam logic [3:0] SIE_OFF_MASK = 4'hC;
    // ------------------------------------------------------------
    // Control word field positions
    // ------------------------------------------------------------
    localparam int SIE_CTL_MODE_LO = 0;
    localparam int SIE_CTL_ODD = 3;
    localparam int SIE_CTL_FEN = 4;
    localparam int SIE_CTL_PEN = 5;
    localparam int SIE_CTL_OEN = 6;
    localparam int SIE_CTL_AUTOBAUD_UNIT_ENABLE = 7;
    localparam int SIE_CTL_AUTOBAUD_FOUND_IRQ_ENABLE = 8;
    localparam int SIE_CTL_AUTOBAUD_START_IRQ_ENABLE = 9;
    localparam int SIE_CTL_FIRST_CHAR_IRQ_ENABLE = 10;
    localparam int SIE_CTL_TXTM = 11;
    localparam int SIE_CTL_FIFO = 12;
    localparam int SIE_CTL_LVL_LO = 16;
    localparam int SIE_CTL_LVL_W = 4;
    localparam int SIE_CTL_W = 20;
    localparam logic [SIE_CTL_W-1:0] SIE_CTL_RESET = 20'h00000;
    // Status bits: 0 frame, 1 parity, 2 overrun
    localparam int SIE_ST_FE = 0;
    localparam int SIE_ST_PE = 1;
    localparam int SIE_ST_OE = 2;
    localparam int SIE_ST_W = 3;
    // ------------------------------------------------------------
    // Frame modes
    // ------------------------------------------------------------
    localparam logic [2:0] SIE_MODE_SYNC = 3'h0;
    localparam logic [2:0] SIE_MODE_8N = 3'h1;
    localparam logic [2:0] SIE_MODE_7P = 3'h3;
    localparam logic [2:0] SIE_MODE_8P = 3'h7;
    // Pulse length of every request line, in module clocks
    localparam int SIE_PULSE_CYC = 2;
    localparam int SIE_BAUD_W = 13;
    localparam int SIE_NCLASS = 9;
    localparam logic [SIE_BAUD_W-1:0] SIE_BAUD_RESET = 13'h0000;

    // Detected format delivered by the autobaud unit
    typedef enum logic [1:0] {
        SIE_FMT_7P = 2'h0,
        SIE_FMT_8P = 2'h1,
        SIE_FMT_8N = 2'h2
    } sie_fmt_t;

    // Autobaud result carrier
    typedef struct packed {
        logic found;
        logic first_char;
        logic start_bit;
        sie_fmt_t fmt;
        logic odd;
        logic [3:0] rate_class;
    } sie_ab_t;

    // Receive completion carrier
    typedef struct packed {
        logic done;
        logic stop_low;
        logic parity_bad;
    } sie_rx_t;

    // Reload value for each rate class
    function automatic logic [SIE_BAUD_W-1:0] sie_reload(input logic [3:0] cls);
        case (cls)
            4'h0: sie_reload = 13'h0002;
            4'h1: sie_reload = 13'h0005;
            4'h2: sie_reload = 13'h000B;
            4'h3: sie_reload = 13'h0011;
            4'h4: sie_reload = 13'h0023;
            4'h5: sie_reload = 13'h0047;
            4'h6: sie_reload = 13'h008F;
            4'h7: sie_reload = 13'h011F;
            default: sie_reload = 13'h023F;
        endcase
    endfunction

    // Mode field for a detected format
    function automatic logic [2:0] sie_mode_of(input sie_fmt_t f);
        case (f)
            SIE_FMT_7P: sie_mode_of = SIE_MODE_7P;
            SIE_FMT_8P: sie_mode_of = SIE_MODE_8P;
            default: sie_mode_of = SIE_MODE_8N;
        endcase
    endfunction
endpackage
`default_nettype wire

/* File: logic/sie_core.sv */
/*
 Interrupt request, receive error and autobaud overwrite logic of a serial
 channel. Assumes the shifters, FIFO and autobaud detector sit outside and
 report events as one-cycle pulses synchronous to clock; software reaches
 the registers over Avalon-MM with waitrequest.
*/
`default_nettype none
`timescale 1ns/100ps

module sie_core
    import sie_pkg::*;
#(
    parameter int FIFO_LVL_W = SIE_CTL_LVL_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Transmit path events
    input wire logic tx_load,
    input wire logic tx_last_async,
    input wire logic tx_eighth_sync,
    input wire logic [FIFO_LVL_W-1:0] tx_fifo_fill,
    // Receive path events
    input wire sie_rx_t rx_evt,
    input wire logic rx_read,
    // Autobaud detector events
    input wire sie_ab_t ab_evt,
    // Request lines
    output logic transmit_irq_line,
    output logic tx_buffer_irq_line,
    output logic receive_irq_line,
    output logic error_irq_line,
    output logic autobaud_irq,
    // Configuration seen by shifters and baud timer, and the level interrupt
    output logic [SIE_CTL_W-1:0] serial_control_word,
    output logic [SIE_BAUD_W-1:0] baud_timer_reload,
    output logic irq
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (FIFO_LVL_W < 1 || FIFO_LVL_W > SIE_CTL_LVL_W) begin : g_chk
        $error("FIFO_LVL_W out of range");
    end

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    logic [SIE_CTL_W-1:0] ctl_r;
    logic [SIE_BAUD_W-1:0] baud_r;
    logic [SIE_ST_W-1:0] stat_r;
    logic [SIE_ST_W-1:0] mask_r;
    logic [2:0] mode;
    logic is_async;
    logic has_parity;
    logic fifo_timed;
    logic [FIFO_LVL_W-1:0] tx_fifo_irq_level;
    assign mode = ctl_r[SIE_CTL_MODE_LO +: 3];
    assign is_async = (mode != SIE_MODE_SYNC);
    assign has_parity = (mode == SIE_MODE_7P) || (mode == SIE_MODE_8P);
    assign fifo_timed = ctl_r[SIE_CTL_FIFO] && !ctl_r[SIE_CTL_TXTM];
    assign tx_fifo_irq_level = ctl_r[SIE_CTL_LVL_LO +: FIFO_LVL_W];

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic wr_ctl, wr_baud, wr_stat, wr_mask;
    logic [SIE_ST_W-1:0] stat_clr;
    assign wr_ctl = avs_write && !avs_waitrequest && (avs_address == SIE_OFF_CTRL);
    assign wr_baud = avs_write && !avs_waitrequest && (avs_address == SIE_OFF_BAUD);
    assign wr_stat = avs_write && !avs_waitrequest && (avs_address == SIE_OFF_STAT);
    assign wr_mask = avs_write && !avs_waitrequest && (avs_address == SIE_OFF_MASK);
    assign stat_clr = (wr_stat && avs_byteenable[0]) ? avs_writedata[SIE_ST_W-1:0] : '0;

    // ------------------------------------------------------------
    // Error detection
    // ------------------------------------------------------------
    logic unread_r;
    logic fe_hit, pe_hit, oe_hit, err_any;
    assign fe_hit = rx_evt.done && is_async && ctl_r[SIE_CTL_FEN] && rx_evt.stop_low;
    assign pe_hit = rx_evt.done && is_async && has_parity && ctl_r[SIE_CTL_PEN]
                    && rx_evt.parity_bad;
    assign oe_hit = rx_evt.done && ctl_r[SIE_CTL_OEN] && unread_r && !rx_read;
    assign err_any = fe_hit || pe_hit || oe_hit;

    // Tracks a character sitting unread in the holding buffer
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            unread_r <= 1'b0;
        end else if (rx_evt.done) begin
            unread_r <= 1'b1;
        end else if (rx_read) begin
            unread_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------
    logic tb_evt, t_evt, ab_start, ab_found, lvl_hit;
    assign lvl_hit = (tx_fifo_fill == tx_fifo_irq_level);
    assign tb_evt = tx_load && (!fifo_timed || lvl_hit);
    assign t_evt = is_async ? (tx_last_async && (!fifo_timed || lvl_hit))
                            : tx_eighth_sync;
    assign ab_start = ab_evt.start_bit && ctl_r[SIE_CTL_AUTOBAUD_UNIT_ENABLE] && ctl_r[SIE_CTL_AUTOBAUD_FOUND_IRQ_ENABLE]
                      && ctl_r[SIE_CTL_AUTOBAUD_START_IRQ_ENABLE];
    assign ab_found = ab_evt.found
                      || (ab_evt.first_char && ctl_r[SIE_CTL_FIRST_CHAR_IRQ_ENABLE]);

    // ------------------------------------------------------------
    // Two-cycle pulse stretchers, one per request line
    // ------------------------------------------------------------
    localparam int NREQ = 5;
    logic [NREQ-1:0] req_evt;
    logic [NREQ-1:0] req_r;
    logic [NREQ-1:0] req_hold_r;
    assign req_evt = {ab_start || ab_found,
                      rx_evt.done && err_any,
                      rx_evt.done,
                      tb_evt, t_evt};
    for (genvar i = 0; i < NREQ; i++) begin : g_pulse
        // Line high in the two cycles following the event
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                req_r[i] <= 1'b0;
                req_hold_r[i] <= 1'b0;
            end else begin
                req_r[i] <= req_evt[i] || (req_r[i] && !req_hold_r[i]);
                req_hold_r[i] <= req_r[i] && !req_hold_r[i] && !req_evt[i];
            end
        end
    end
    assign transmit_irq_line = req_r[0];
    assign tx_buffer_irq_line = req_r[1];
    assign receive_irq_line = req_r[2];
    assign error_irq_line = req_r[3];
    assign autobaud_irq = req_r[4];

    // ------------------------------------------------------------
    // Control word: software writes, autobaud overwrites
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctl_r <= SIE_CTL_RESET;
        end else if (ab_evt.found) begin
            ctl_r[SIE_CTL_MODE_LO +: 3] <= sie_mode_of(ab_evt.fmt);
            ctl_r[SIE_CTL_ODD] <= ab_evt.odd && (ab_evt.fmt != SIE_FMT_8N);
        end else if (wr_ctl) begin
            ctl_r <= avs_writedata[SIE_CTL_W-1:0];
        end
    end

    // Baud reload: software writes, autobaud overwrites
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            baud_r <= SIE_BAUD_RESET;
        end else if (ab_evt.found) begin
            baud_r <= sie_reload(ab_evt.rate_class);
        end else if (wr_baud) begin
            baud_r <= avs_writedata[SIE_BAUD_W-1:0];
        end
    end
    assign serial_control_word = ctl_r;
    assign baud_timer_reload = baud_r;

    // ------------------------------------------------------------
    // Sticky error flags, write one to clear, set wins
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stat_r <= '0;
        end else begin
            stat_r <= (stat_r & ~stat_clr) | {oe_hit, pe_hit, fe_hit};
        end
    end

    // Mask register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mask_r <= '0;
        end else if (wr_mask) begin
            mask_r <= avs_writedata[SIE_ST_W-1:0];
        end
    end

    // Level interrupt from unmasked sticky flags
    logic irq_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(((stat_r & ~stat_clr) | {oe_hit, pe_hit, fe_hit}) & mask_r);
        end
    end
    assign irq = irq_r;

    // ------------------------------------------------------------
    // Bus answer: one wait cycle, then data
    // ------------------------------------------------------------
    logic wait_r;
    logic [31:0] rdata_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= !((avs_read || avs_write) && wait_r);
        end
    end
    assign avs_waitrequest = wait_r;

    // Read mux, unmapped reads zero
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= '0;
        end else begin
            case (avs_address)
                SIE_OFF_CTRL: rdata_r <= {{(32-SIE_CTL_W){1'b0}}, ctl_r};
                SIE_OFF_BAUD: rdata_r <= {{(32-SIE_BAUD_W){1'b0}}, baud_r};
                SIE_OFF_STAT: rdata_r <= {{(32-SIE_ST_W){1'b0}}, stat_r};
                SIE_OFF_MASK: rdata_r <= {{(32-SIE_ST_W){1'b0}}, mask_r};
                default: rdata_r <= '0;
            endcase
        end
    end
    assign avs_readdata = rdata_r;
endmodule // sie_core
`default_nettype wire

/* File: test/sie_core_asserts.sv */
/*
 Checker for sie_core request pulses, error causes and autobaud overwrite.
 Assumes it is bound to sie_core and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module sie_core_asserts
    import sie_pkg::*;
#(
    parameter int FIFO_LVL_W = SIE_CTL_LVL_W
) (
    // Clock and reset
    input wire logic clock, input wire logic rstn,
    // Event inputs
    input wire logic tx_load, input wire logic tx_last_async, input wire logic [FIFO_LVL_W-1:0] tx_fifo_fill,
    input wire sie_rx_t rx_evt, input wire sie_ab_t ab_evt,
    // Request lines and configuration
    input wire logic transmit_irq_line, input wire logic tx_buffer_irq_line, input wire logic receive_irq_line,
    input wire logic error_irq_line, input wire logic autobaud_irq,
    input wire logic [SIE_CTL_W-1:0] serial_control_word, input wire logic [SIE_BAUD_W-1:0] baud_timer_reload
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // Decoded control: async mode, parity modes, FIFO level gate, start enables
    wire logic [SIE_CTL_W-1:0] c = serial_control_word;
    wire logic asy = c[2:0] != SIE_MODE_SYNC;
    wire logic par = (c[2:0] == SIE_MODE_7P) || (c[2:0] == SIE_MODE_8P);
    wire logic lvl = !c[SIE_CTL_FIFO] || c[SIE_CTL_TXTM] || tx_fifo_fill == FIFO_LVL_W'(c[19:16]);
    wire logic ab3 = c[SIE_CTL_AUTOBAUD_UNIT_ENABLE] && c[SIE_CTL_AUTOBAUD_FOUND_IRQ_ENABLE] && c[SIE_CTL_AUTOBAUD_START_IRQ_ENABLE];
    // Two cycles without the event
    sequence s_quiet(e);
        !e ##1 !e;
    endsequence
    a_rx_pulse: assert property (rx_evt.done |=> receive_irq_line [*2]) else $error("rx pulse");
    a_rx_quiet: assert property (s_quiet(rx_evt.done) |=> !receive_irq_line) else $error("rx long");
    a_transmit_holding_buffer_pulse: assert property (tx_load && lvl |=> tx_buffer_irq_line [*2]) else $error("transmit_holding_buffer");
    a_tir_async: assert property (tx_last_async && asy && lvl |=> transmit_irq_line [*2])
        else $error("tir");
    a_err_rx: assert property (error_irq_line |-> receive_irq_line) else $error("err alone");
    a_frame_err: assert property (rx_evt.done && rx_evt.stop_low && c[SIE_CTL_FEN] && asy |=> error_irq_line [*2])
        else $error("frame");
    a_parity_err: assert property (rx_evt.done && rx_evt.parity_bad && c[SIE_CTL_PEN] && par
        |=> error_irq_line) else $error("parity");
    a_ab_found: assert property (ab_evt.found |=> autobaud_irq [*2]) else $error("ab found");
    a_ab_start: assert property (ab_evt.start_bit && ab3 |=> autobaud_irq [*2]) else $error("ab start");
    a_ab_odd: assert property (ab_evt.found |=> c[SIE_CTL_ODD] == $past(ab_evt.odd && ab_evt.fmt != SIE_FMT_8N))
        else $error("ab odd");
    a_ab_mode: assert property (ab_evt.found && ab_evt.fmt == SIE_FMT_8N |=> c[2:0] == SIE_MODE_8N)
        else $error("ab mode");
    a_reload_fast: assert property (ab_evt.found && ab_evt.rate_class == 4'h0
        |=> baud_timer_reload == 13'h0002) else $error("reload fast");
    a_reload_slow: assert property (ab_evt.found && ab_evt.rate_class == 4'h8
        |=> baud_timer_reload == 13'h023F) else $error("reload slow");
endmodule // sie_core_asserts
`default_nettype wire

/* File: test/sie_partner.sv */
/*
 Far-side model: remote serial node and buffer service, as event pulses.
 Assumes the bench calls its tasks from one process, on the block clock.
*/
`timescale 1ns/100ps
`default_nettype none
module sie_partner
    import sie_pkg::*;
(
    // Clock
    input wire logic clock,
    // Events toward the block
    output var logic [2:0] tx_evt,
    output var logic [3:0] tx_fifo_fill,
    output var sie_rx_t rx_evt,
    output var logic rx_read,
    output var sie_ab_t ab_evt
);
    // Idle at time zero
    initial {tx_evt, tx_fifo_fill, rx_evt, rx_read, ab_evt} = '0;
    // One-cycle event; once it drops, qualifiers turn to their inverse
    task pulse(input sie_ab_t a, input sie_rx_t r, input logic [2:0] t, input logic rd);
        @(posedge clock);
        {ab_evt, rx_evt, tx_evt, rx_read} <= {a, r, t, rd};
        @(posedge clock);
        {ab_evt, rx_evt, tx_evt, rx_read} <= {3'h0, ~a[6:0], 1'b0, ~r[1:0], 4'h0};
    endtask
    // Transmit FIFO fill as the FIFO reports it
    task fill(input logic [3:0] f);
        @(posedge clock);
        tx_fifo_fill <= f;
    endtask
endmodule // sie_partner
`default_nettype wire

/* File: test/tb.sv */
/*
 Bench for sie_core: events from the partner model, registers over Avalon-MM.
 Assumes package, checker and partner are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
    import sie_pkg::*;
    // ----------------------------------------
    // Signals, tables, instances
    // ----------------------------------------
    logic clock, rstn, avs_read, avs_write, avs_waitrequest, irq, rx_read;
    logic transmit_irq_line, tx_buffer_irq_line, receive_irq_line, error_irq_line, autobaud_irq;
    logic [3:0] avs_address, avs_byteenable, tx_fifo_fill;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [2:0] tx_evt;
    sie_rx_t rx_evt;
    sie_ab_t ab_evt, a;
    logic [SIE_CTL_W-1:0] serial_control_word;
    logic [SIE_BAUD_W-1:0] baud_timer_reload;
    int errors, n_checks;
    logic [12:0] rel [9] = '{13'h002, 13'h005, 13'h00B, 13'h011, 13'h023, 13'h047, 13'h08F, 13'h11F, 13'h23F};
    logic [2:0] md [3] = '{3'h3, 3'h7, 3'h1};
    wire logic [4:0] lines = {autobaud_irq, error_irq_line, receive_irq_line, tx_buffer_irq_line, transmit_irq_line};
    sie_core DUT (.clock, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .tx_load(tx_evt[0]), .tx_last_async(tx_evt[1]), .tx_eighth_sync(tx_evt[2]), .tx_fifo_fill,
        .rx_evt, .rx_read, .ab_evt, .transmit_irq_line, .tx_buffer_irq_line, .receive_irq_line, .error_irq_line,
        .autobaud_irq, .serial_control_word, .baud_timer_reload, .irq);
    sie_partner P (.clock, .tx_evt, .tx_fifo_fill, .rx_evt, .rx_read, .ab_evt);
    // 50 ns clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Compare and count
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One bus access, held until waitrequest is seen low at a rising edge; read data lands in q
    task bus(input logic wr, input logic [3:0] ad, input logic [31:0] d);
        @(posedge clock);
        avs_address <= ad;
        avs_writedata <= d;
        {avs_write, avs_read} <= {wr, !wr};
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        {avs_write, avs_read} <= 2'h0;
        avs_address <= ~ad;
        avs_writedata <= ~d;
    endtask
    // Event pulse, then the request lines over the next three cycles
    task fire(input string nm, input sie_ab_t ea, input sie_rx_t er, input logic [2:0] et, input logic [4:0] e);
        P.pulse(ea, er, et, 1'b0);
        for (int k = 0; k < 3; k++) begin
            #1;
            chk(nm, (k < 2) ? e : 5'h00, lines);
            if (k < 2) @(posedge clock);
        end
    endtask
    // Transmit requests, per word and by FIFO level
    task t_tx();
        bus(1'b1, SIE_OFF_CTRL, 32'h1);
        fire("transmit_holding_buffer", '0, '0, 3'h1, 5'h02);
        fire("tir async", '0, '0, 3'h2, 5'h01);
        bus(1'b1, SIE_OFF_CTRL, 32'h0);
        fire("tir sync", '0, '0, 3'h4, 5'h01);
        bus(1'b1, SIE_OFF_CTRL, 32'h51001);
        P.fill(4'h3);
        fire("fifo below", '0, '0, 3'h3, 5'h00);
        P.fill(4'h5);
        fire("fifo level", '0, '0, 3'h3, 5'h03);
        bus(1'b1, SIE_OFF_CTRL, 32'h51801);
        P.fill(4'h3);
        fire("transparent", '0, '0, 3'h3, 5'h03);
        $display("t_tx done");
    endtask
    // Receive errors, sticky flags, mask and overrun
    task t_rx();
        bus(1'b1, SIE_OFF_MASK, 32'h3);
        bus(1'b1, SIE_OFF_CTRL, 32'h73);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, q);
        fire("all errors", '0, 3'h7, 3'h0, 5'h0C);
        chk("irq", 32'h1, irq);
        bus(1'b0, SIE_OFF_STAT, 32'h0);
        chk("status", 32'h3, q);
        bus(1'b1, SIE_OFF_STAT, 32'h1);
        bus(1'b0, SIE_OFF_STAT, 32'h0);
        chk("status w1c", 32'h2, q);
        bus(1'b1, SIE_OFF_STAT, 32'h7);
        bus(1'b0, SIE_OFF_STAT, 32'h0);
        chk("status clear", 32'h0, q);
        chk("irq clear", 32'h0, irq);
        P.pulse('0, '0, 3'h0, 1'b1);
        fire("clean", '0, 3'h4, 3'h0, 5'h04);
        fire("overrun", '0, 3'h4, 3'h0, 5'h0C);
        chk("irq masked", 32'h0, irq);
        bus(1'b0, SIE_OFF_STAT, 32'h0);
        chk("status overrun", 32'h4, q);
        bus(1'b1, SIE_OFF_CTRL, 32'h70);
        bus(1'b1, SIE_OFF_STAT, 32'h7);
        P.pulse('0, '0, 3'h0, 1'b1);
        fire("sync no error", '0, 3'h6, 3'h0, 5'h04);
        $display("t_rx done");
    endtask
    // Autobaud requests and overwrite of mode, parity sense and reload
    task t_ab();
        bus(1'b1, SIE_OFF_CTRL, 32'h380);
        a = '0;
        a.start_bit = 1'b1;
        fire("ab start", a, '0, 3'h0, 5'h10);
        bus(1'b1, SIE_OFF_CTRL, 32'h180);
        fire("ab start off", a, '0, 3'h0, 5'h00);
        a = '0;
        a.first_char = 1'b1;
        fire("first off", a, '0, 3'h0, 5'h00);
        bus(1'b1, SIE_OFF_CTRL, 32'h580);
        fire("first on", a, '0, 3'h0, 5'h10);
        for (int i = 0; i < 9; i++) begin
            a = '0;
            a.found = 1'b1;
            a.fmt = sie_fmt_t'(2'(i % 3));
            a.odd = (i % 3 != 2) && i[0];
            a.rate_class = 4'(i);
            fire("ab found", a, '0, 3'h0, 5'h10);
            chk("reload", 32'(rel[i]), 32'(baud_timer_reload));
            chk("mode", 32'({a.odd, md[i % 3]}), 32'(serial_control_word[3:0]));
        end
        $display("t_ab done");
    endtask
    // Report counts and verdict, then stop
    task finish_test();
        $display("Checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Watchdog well above the expected run
    initial begin
        #1000000;
        errors++;
        finish_test();
    end
    // Reset, then the tests
    initial begin
        {rstn, avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hF;
        errors = 0;
        n_checks = 0;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        #1;
        chk("waitrequest", 32'h1, avs_waitrequest);
        chk("control", 32'h0, 32'(serial_control_word));
        t_tx();
        t_rx();
        t_ab();
        finish_test();
    end
endmodule // tb
bind sie_core sie_core_asserts #(.FIFO_LVL_W(FIFO_LVL_W)) u_chk (.clock, .rstn, .tx_load, .tx_last_async,
    .tx_fifo_fill, .rx_evt, .ab_evt, .transmit_irq_line, .tx_buffer_irq_line, .receive_irq_line, .error_irq_line,
    .autobaud_irq, .serial_control_word, .baud_timer_reload);
`default_nettype wire
